/* File: pwm_channel.sv */
// Purpose: One 16-bit down-counting waveform timer with reload and compare
// Assumes: tick is a one-cycle pulse from the divider chain on ref_clk
// Notes: done is combinational so the start bit clears on the stopping edge
module pwm_channel
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic tick,
    input pwm_timer_pkg::chan_cfg_s cfg,
    input wire logic [15:0] reload,
    input wire logic [15:0] threshold,
    output logic [15:0] count,
    output logic pwm,
    output logic done
);
    import pwm_timer_pkg::*;

    chan_state_s st_ff;
    chan_state_s nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        done = 1'b0;
        if (!cfg.start)
        begin
            nxt_st.run = 1'b0;
        end
        else if (!st_ff.run)
        begin
            nxt_st.run = 1'b1;
            nxt_st.count = reload;
        end
        else if (tick)
        begin
            if (st_ff.count == WORD_RESET)
            begin
                if (cfg.auto_rl)
                begin
                    nxt_st.count = reload;
                end
                else
                begin
                    nxt_st.run = 1'b0;
                    done = 1'b1;
                end
            end
            else
            begin
                nxt_st.count = st_ff.count - COUNT_ONE;
            end
        end
        if (st_ff.run)
        begin
            nxt_st.pwm = (st_ff.count <= threshold) ^ cfg.inv;
        end
        else
        begin
            nxt_st.pwm = cfg.inv;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign count = st_ff.count;
    assign pwm = st_ff.pwm;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence at_zero;
        st_ff.run && cfg.start && tick && st_ff.count == WORD_RESET;
    endsequence

    sequence stepping;
        st_ff.run && cfg.start && tick && st_ff.count != WORD_RESET;
    endsequence

    reload_at_zero_a: assert property (at_zero ##0 cfg.auto_rl |=>
        st_ff.run && st_ff.count == $past(reload))
        else $error("counter did not reload at zero");

    count_step_a: assert property (stepping |=>
        st_ff.count == $past(st_ff.count) - COUNT_ONE)
        else $error("counter did not step down by one");

    oneshot_stop_a: assert property (at_zero ##0 !cfg.auto_rl |-> done ##1
        !st_ff.run)
        else $error("one-shot timer did not stop at zero");

    compare_level_a: assert property (st_ff.run |=>
        pwm == (($past(st_ff.count) <= $past(threshold)) ^ $past(cfg.inv)))
        else $error("waveform level disagrees with compare");

    idle_invert_a: assert property (!st_ff.run |=> pwm == $past(cfg.inv))
        else $error("stopped output ignores inverter");
endmodule

/* File: pwm_reload_compare.sv */
// Purpose: Reload and compare registers for two waveform timers, with the timers
// Assumes: Plain register port, read data one cycle after the read strobe
// Notes: Tick inputs come from the prescaler chain on the same clock
//
// Our own choice: the address-and-strobe port.
import pwm_timer_pkg::*;

// Contract
// - Timer 0 reload value is 16 bits held in separately writable low and high bytes.
// - Timer 1 reload value is 16 bits held in separately writable low and high bytes.
// - Timer 0 counter reloads the 16-bit reload value at zero when auto-reload is on.
// - Timer 1 counter reloads the 16-bit reload value at zero when auto-reload is on.
// - While timer 0 is started its reload bytes read back the live counter.
// - While timer 1 is started its reload bytes read back the live counter.
// - Timer 1 threshold is 16 bits held in a low byte and a high byte.
// - Timer 1 output is high while its counter is at or below its threshold, uninverted.
// - Timer 0 output is high while its counter is at or below its threshold, uninverted.
// - Each timer has an auto-reload bit, clear for one-shot, set for interval, reset set.
// - One-shot timers clear their own start bit; interval timers stop when software clears it.
// - Each timer has an inverter bit that reverses its output polarity.
module pwm_reload_compare
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic tick0,
    input wire logic tick1,
    output logic [7:0] rdata,
    output logic pwm0_out,
    output logic pwm1_out
);
    import pwm_timer_pkg::*;

    regs_s r_ff;
    regs_s nxt_r;
    chan_cfg_s cfg0;
    chan_cfg_s cfg1;
    logic [15:0] count0;
    logic [15:0] count1;
    logic done0;
    logic done1;

    assign cfg0 = '{start: r_ff.cfg[CFG_T0_START], auto_rl: r_ff.cfg[CFG_T0_AUTO],
        inv: r_ff.cfg[CFG_T0_INV]};
    assign cfg1 = '{start: r_ff.cfg[CFG_T1_START], auto_rl: r_ff.cfg[CFG_T1_AUTO],
        inv: r_ff.cfg[CFG_T1_INV]};

    pwm_channel u_timer0
    (
        .ref_clk(ref_clk),
        .reset(reset),
        .tick(tick0),
        .cfg(cfg0),
        .reload(r_ff.rld0),
        .threshold(r_ff.thr0),
        .count(count0),
        .pwm(pwm0_out),
        .done(done0)
    );

    pwm_channel u_timer1
    (
        .ref_clk(ref_clk),
        .reset(reset),
        .tick(tick1),
        .cfg(cfg1),
        .reload(r_ff.rld1),
        .threshold(r_ff.thr1),
        .count(count1),
        .pwm(pwm1_out),
        .done(done1)
    );

    always_comb
    begin
        nxt_r = r_ff;
        nxt_r.rdata = BYTE_RESET;
        if (done0)
        begin
            nxt_r.cfg[CFG_T0_START] = 1'b0;
        end
        if (done1)
        begin
            nxt_r.cfg[CFG_T1_START] = 1'b0;
        end
        // Write after the clear so a start written on the stopping edge wins
        if (wr_stb)
        begin
            if (addr == CFG_ADDR)
            begin
                nxt_r.cfg = wdata & CFG_WR_MASK;
            end
            else if (addr == T0_THR_LO)
            begin
                nxt_r.thr0[7:0] = wdata;
            end
            else if (addr == T0_THR_HI)
            begin
                nxt_r.thr0[15:8] = wdata;
            end
            else if (addr == T0_RLD_LO)
            begin
                nxt_r.rld0[7:0] = wdata;
            end
            else if (addr == T0_RLD_HI)
            begin
                nxt_r.rld0[15:8] = wdata;
            end
            else if (addr == T1_THR_LO)
            begin
                nxt_r.thr1[7:0] = wdata;
            end
            else if (addr == T1_THR_HI)
            begin
                nxt_r.thr1[15:8] = wdata;
            end
            else if (addr == T1_RLD_LO)
            begin
                nxt_r.rld1[7:0] = wdata;
            end
            else if (addr == T1_RLD_HI)
            begin
                nxt_r.rld1[15:8] = wdata;
            end
        end
        if (rd_stb)
        begin
            if (addr == CFG_ADDR)
            begin
                nxt_r.rdata = r_ff.cfg;
            end
            else if (addr == T0_THR_LO)
            begin
                nxt_r.rdata = r_ff.thr0[7:0];
            end
            else if (addr == T0_THR_HI)
            begin
                nxt_r.rdata = r_ff.thr0[15:8];
            end
            else if (addr == T0_RLD_LO)
            begin
                nxt_r.rdata = cfg0.start ? count0[7:0] : r_ff.rld0[7:0];
            end
            else if (addr == T0_RLD_HI)
            begin
                nxt_r.rdata = cfg0.start ? count0[15:8] : r_ff.rld0[15:8];
            end
            else if (addr == T1_THR_LO)
            begin
                nxt_r.rdata = r_ff.thr1[7:0];
            end
            else if (addr == T1_THR_HI)
            begin
                nxt_r.rdata = r_ff.thr1[15:8];
            end
            else if (addr == T1_RLD_LO)
            begin
                nxt_r.rdata = cfg1.start ? count1[7:0] : r_ff.rld1[7:0];
            end
            else if (addr == T1_RLD_HI)
            begin
                nxt_r.rdata = cfg1.start ? count1[15:8] : r_ff.rld1[15:8];
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            r_ff.cfg <= CFG_RESET;
            r_ff.thr0 <= WORD_RESET;
            r_ff.rld0 <= WORD_RESET;
            r_ff.thr1 <= WORD_RESET;
            r_ff.rld1 <= WORD_RESET;
            r_ff.rdata <= BYTE_RESET;
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    assign rdata = r_ff.rdata;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence cfg_write;
        wr_stb && addr == CFG_ADDR;
    endsequence

    sequence rd_of(logic [7:0] a);
        rd_stb && addr == a;
    endsequence

    reload0_bytes_a: assert property (wr_stb && addr == T0_RLD_HI ##1
        rd_of(T0_RLD_HI) ##0 !cfg0.start |=> rdata == $past(wdata, 2))
        else $error("timer 0 reload high byte lost");

    reload1_low_a: assert property (wr_stb && addr == T1_RLD_LO |=>
        r_ff.rld1[7:0] == $past(wdata) && r_ff.rld1[15:8] == $past(r_ff.rld1[15:8]))
        else $error("timer 1 reload low byte not stored alone");

    live_read0_a: assert property (rd_of(T0_RLD_LO) ##0 cfg0.start |=>
        rdata == $past(count0[7:0]))
        else $error("timer 0 live count not returned");

    live_read1_a: assert property (rd_of(T1_RLD_HI) ##0 cfg1.start |=>
        rdata == $past(count1[15:8]))
        else $error("timer 1 live count not returned");

    thr1_bytes_a: assert property (wr_stb && addr == T1_THR_HI |=>
        r_ff.thr1[15:8] == $past(wdata) && r_ff.thr1[7:0] == $past(r_ff.thr1[7:0]))
        else $error("timer 1 threshold high byte not stored");

    reset_mode_a: assert property (disable iff (1'b0) reset |=>
        cfg0.auto_rl && cfg1.auto_rl && !cfg0.start && !cfg1.start)
        else $error("mode bits wrong after reset");

    self_clear_a: assert property (done0 && !(wr_stb && addr == CFG_ADDR) |=>
        !cfg0.start)
        else $error("one-shot start bit not cleared");

    interval_hold_a: assert property (cfg1.start && cfg1.auto_rl &&
        !(wr_stb && addr == CFG_ADDR) |=> cfg1.start)
        else $error("interval start bit dropped by hardware");

    unmapped_zero_a: assert property (rd_stb && (addr < CFG_ADDR || addr > T1_RLD_HI) |=>
        rdata == BYTE_RESET)
        else $error("unmapped read not zero");

    sequence start0;
        !cfg0.start ##1 cfg0.start;
    endsequence

    sequence start1;
        !cfg1.start ##1 cfg1.start;
    endsequence

    // Software write wins over a one-shot clear in the same cycle
    cfg_store_a: assert property (cfg_write |=>
        r_ff.cfg == ($past(wdata) & CFG_WR_MASK))
        else $error("config write not stored");

    reload0_low_a: assert property (wr_stb && addr == T0_RLD_LO |=>
        r_ff.rld0[7:0] == $past(wdata) && r_ff.rld0[15:8] == $past(r_ff.rld0[15:8]))
        else $error("timer 0 reload low byte not stored alone");

    reload1_high_a: assert property (wr_stb && addr == T1_RLD_HI |=>
        r_ff.rld1[15:8] == $past(wdata) && r_ff.rld1[7:0] == $past(r_ff.rld1[7:0]))
        else $error("timer 1 reload high byte not stored alone");

    thr1_low_a: assert property (wr_stb && addr == T1_THR_LO |=>
        r_ff.thr1[7:0] == $past(wdata) && r_ff.thr1[15:8] == $past(r_ff.thr1[15:8]))
        else $error("timer 1 threshold low byte not stored alone");

    live_read0_hi_a: assert property (rd_of(T0_RLD_HI) ##0 cfg0.start |=>
        rdata == $past(count0[15:8]))
        else $error("timer 0 live high byte not returned");

    live_read1_lo_a: assert property (rd_of(T1_RLD_LO) ##0 cfg1.start |=>
        rdata == $past(count1[7:0]))
        else $error("timer 1 live low byte not returned");

    stored_read1_a: assert property (rd_of(T1_RLD_HI) ##0 !cfg1.start |=>
        rdata == $past(r_ff.rld1[15:8]))
        else $error("timer 1 stored reload byte not returned");

    rdata_idle_a: assert property (!rd_stb |=> rdata == BYTE_RESET)
        else $error("read data outlived its cycle");

    self_clear1_a: assert property (done1 && !(wr_stb && addr == CFG_ADDR) |=>
        !cfg1.start)
        else $error("timer 1 one-shot start bit not cleared");

    interval_hold0_a: assert property (cfg0.start && cfg0.auto_rl &&
        !(wr_stb && addr == CFG_ADDR) |=> cfg0.start)
        else $error("timer 0 interval start bit dropped by hardware");

    idle_level0_a: assert property (!cfg0.start ##1 !cfg0.start |=>
        pwm0_out == $past(cfg0.inv))
        else $error("stopped timer 0 output ignores inverter");

    idle_level1_a: assert property (!cfg1.start ##1 !cfg1.start |=>
        pwm1_out == $past(cfg1.inv))
        else $error("stopped timer 1 output ignores inverter");

    start_load0_a: assert property (start0 |=> count0 == $past(r_ff.rld0))
        else $error("timer 0 did not load on start");

    start_load1_a: assert property (start1 |=> count1 == $past(r_ff.rld1))
        else $error("timer 1 did not load on start");

    reset_regs_a: assert property (disable iff (1'b0) reset |=>
        r_ff.rld0 == WORD_RESET && r_ff.rld1 == WORD_RESET && r_ff.thr1 == WORD_RESET &&
        !pwm0_out && !pwm1_out && rdata == BYTE_RESET)
        else $error("buffers or outputs wrong after reset");
endmodule

/* File: pwm_reload_compare_tb_top.sv */
// Purpose: Self-checking bench for the dual waveform timer reload and compare block
// Assumes: Ticks are driven by the bench as one-cycle pulses on ref_clk
// Notes: Live counts are read back as two byte snapshots with no tick in between
module pwm_reload_compare_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pwm_timer_pkg::*;

    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic tick0 = 1'b0;
    logic tick1 = 1'b0;
    logic [7:0] rdata;
    logic pwm0_out;
    logic pwm1_out;
    int error_cnt = 0;
    int n_tests = 0;

    pwm_reload_compare i_dut
    (
        .ref_clk(ref_clk),
        .reset(reset),
        .addr(addr),
        .wdata(wdata),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .tick0(tick0),
        .tick1(tick1),
        .rdata(rdata),
        .pwm0_out(pwm0_out),
        .pwm1_out(pwm1_out)
    );

    always #25 ref_clk = ~ref_clk;

    task automatic give_verdict();
        $display("errors %0d, comparisons %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: output level %b, expected %b", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr_stb <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask

    // Read data stands one cycle only, then falls back to zero
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1;
        chk8(rdata, exp);
        @(posedge ref_clk);
        #1;
        chk8(rdata, BYTE_RESET);
    endtask

    task automatic rd16(input logic [7:0] lo, input logic [15:0] exp);
        rd(lo, exp[7:0]);
        rd(lo + 8'h01, exp[15:8]);
    endtask

    task automatic pulse(input int ch);
        @(posedge ref_clk);
        if (ch == 0)
            tick0 <= 1'b1;
        else
            tick1 <= 1'b1;
        @(posedge ref_clk);
        tick0 <= 1'b0;
        tick1 <= 1'b0;
    endtask

    task automatic t_reset_values();
        chk1(pwm0_out, 1'b0);
        chk1(pwm1_out, 1'b0);
        for (int a = 'h86; a <= 'h90; a++)
            rd(a[7:0], (a[7:0] == CFG_ADDR) ? CFG_RESET : BYTE_RESET);
    endtask

    task automatic t_byte_regs();
        // Distinct pattern per byte catches swapped halves
        for (int a = 'h88; a <= 'h8f; a++)
            wr(a[7:0], a[7:0] ^ 8'h5a);
        wr(8'h90, 8'hff);
        wr(CFG_ADDR, 8'ha2);
        for (int a = 'h88; a <= 'h8f; a++)
            rd(a[7:0], a[7:0] ^ 8'h5a);
        rd(8'h90, BYTE_RESET);
        rd(CFG_ADDR, CFG_RESET);
    endtask

    task automatic t_oneshot(input int ch);
        logic [7:0] rl;
        logic [7:0] th;
        rl = (ch == 0) ? T0_RLD_LO : T1_RLD_LO;
        th = (ch == 0) ? T0_THR_LO : T1_THR_LO;
        wr(rl, 8'h02);
        wr(rl + 8'h01, 8'h00);
        wr(th, 8'h01);
        wr(th + 8'h01, 8'h00);
        wr(CFG_ADDR, 8'h01 << (4 * ch));
        repeat (3) @(posedge ref_clk);
        rd16(rl, 16'h0002);
        chk1(ch ? pwm1_out : pwm0_out, 1'b0);
        pulse(ch);
        rd16(rl, 16'h0001);
        chk1(ch ? pwm1_out : pwm0_out, 1'b1);
        pulse(ch);
        rd16(rl, 16'h0000);
        chk1(ch ? pwm1_out : pwm0_out, 1'b1);
        pulse(ch);
        rd(CFG_ADDR, 8'h00);
        chk1(ch ? pwm1_out : pwm0_out, 1'b0);
        rd16(rl, 16'h0002);
        wr(CFG_ADDR, CFG_RESET);
    endtask

    task automatic t_interval(input int ch);
        logic [7:0] rl;
        logic [7:0] th;
        rl = (ch == 0) ? T0_RLD_LO : T1_RLD_LO;
        th = (ch == 0) ? T0_THR_LO : T1_THR_LO;
        wr(rl, 8'h01);
        wr(rl + 8'h01, 8'h00);
        wr(th, 8'h00);
        wr(th + 8'h01, 8'h00);
        wr(CFG_ADDR, 8'h07 << (4 * ch));
        repeat (3) @(posedge ref_clk);
        rd16(rl, 16'h0001);
        chk1(ch ? pwm1_out : pwm0_out, 1'b1);
        pulse(ch);
        rd16(rl, 16'h0000);
        chk1(ch ? pwm1_out : pwm0_out, 1'b0);
        pulse(ch);
        rd16(rl, 16'h0001);
        chk1(ch ? pwm1_out : pwm0_out, 1'b1);
        rd(CFG_ADDR, 8'h07 << (4 * ch));
        // Software stop with the inverter left on shows the inverted idle level
        wr(CFG_ADDR, 8'h04 << (4 * ch));
        repeat (3) @(posedge ref_clk);
        chk1(ch ? pwm1_out : pwm0_out, 1'b1);
        rd(CFG_ADDR, 8'h04 << (4 * ch));
        wr(CFG_ADDR, CFG_RESET);
        repeat (3) @(posedge ref_clk);
        chk1(ch ? pwm1_out : pwm0_out, 1'b0);
    endtask

    // Read issued in the cycle right after the write sees the new byte
    task automatic t_back_to_back();
        @(posedge ref_clk);
        wr_stb <= 1'b1;
        addr <= T0_RLD_HI;
        wdata <= 8'h3c;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1;
        chk8(rdata, 8'h3c);
    endtask

    // Reset in mid-run must stop a running timer and restore the read data, config and timer 1 reload low byte
    task automatic t_mid_reset();
        wr(T1_RLD_LO, 8'h05);
        wr(CFG_ADDR, 8'h30);
        repeat (3) @(posedge ref_clk);
        pulse(1);
        rd(T1_RLD_LO, 8'h04);
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk8(rdata, BYTE_RESET);
        chk1(pwm1_out, 1'b0);
        rd(CFG_ADDR, CFG_RESET);
        rd(T1_RLD_LO, BYTE_RESET);
    endtask

    // Hang guard; every scenario uses fixed cycle counts only
    initial
    begin
        repeat (100000) @(posedge ref_clk);
        error_cnt++;
        $display("mismatch at %0t: run did not finish", $time);
        give_verdict();
    end

    initial
    begin
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk8(rdata, BYTE_RESET);
        t_reset_values();
        t_byte_regs();
        t_back_to_back();
        t_oneshot(0);
        t_oneshot(1);
        t_interval(0);
        t_interval(1);
        t_mid_reset();
        give_verdict();
    end
endmodule

/* File: pwm_timer_pkg.sv */
// Purpose: Shared constants and carriers for the dual waveform timer block
// Assumes: Byte-wide register port, 20 MHz ref_clk, ticks made elsewhere
// Notes: Offsets are byte addresses on the plain register port
package pwm_timer_pkg;
    localparam logic [7:0] CFG_ADDR = 8'h86;
    localparam logic [7:0] T0_THR_LO = 8'h88;
    localparam logic [7:0] T0_THR_HI = 8'h89;
    localparam logic [7:0] T0_RLD_LO = 8'h8a;
    localparam logic [7:0] T0_RLD_HI = 8'h8b;
    localparam logic [7:0] T1_THR_LO = 8'h8c;
    localparam logic [7:0] T1_THR_HI = 8'h8d;
    localparam logic [7:0] T1_RLD_LO = 8'h8e;
    localparam logic [7:0] T1_RLD_HI = 8'h8f;

    localparam int CFG_T0_START = 0;
    localparam int CFG_T0_AUTO = 1;
    localparam int CFG_T0_INV = 2;
    localparam int CFG_T0_DZ = 3;
    localparam int CFG_T1_START = 4;
    localparam int CFG_T1_AUTO = 5;
    localparam int CFG_T1_INV = 6;
    localparam int CFG_NA = 7;

    localparam logic [7:0] CFG_RESET = 8'h22;
    localparam logic [7:0] CFG_WR_MASK = 8'h7f;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [15:0] COUNT_ONE = 16'h0001;

    typedef struct packed {
        logic start;
        logic auto_rl;
        logic inv;
    } chan_cfg_s;

    typedef struct packed {
        logic run;
        logic [15:0] count;
        logic pwm;
    } chan_state_s;

    typedef struct packed {
        logic [7:0] cfg;
        logic [15:0] thr0;
        logic [15:0] rld0;
        logic [15:0] thr1;
        logic [15:0] rld1;
        logic [7:0] rdata;
    } regs_s;
endpackage
